//--- include/ictl_cfg.svh
/*
  timing, threshold and default constants for the isolated can
  transceiver logic model.
  assumes a 250 MHz core clock (4 ns period).
*/
`ifndef ICTL_CFG_SVH
`define ICTL_CFG_SVH

`define ICTL_CLK_PERIOD_PS 4000
`define ICTL_REFRESH_NS 1000
`define ICTL_WATCHDOG_NS 5000
`define ICTL_PULSE_NS 1
// refresh is a longest time (round down), watchdog a least time (round up)
`define ICTL_REFRESH_CYC ((`ICTL_REFRESH_NS * 1000) / `ICTL_CLK_PERIOD_PS)
`define ICTL_WATCHDOG_CYC \
  ((`ICTL_WATCHDOG_NS * 1000 + `ICTL_CLK_PERIOD_PS - 1) / `ICTL_CLK_PERIOD_PS)
`define ICTL_CNT_W 12
// differential thresholds in millivolts
`define ICTL_DOM_MV 16'h0384
`define ICTL_REC_MV 16'h01F4
`define ICTL_VID_W 16
// die temperature thresholds in degrees C
`define ICTL_TSD_ON_C 8'h96
`define ICTL_TSD_OFF_C 8'h8C
`define ICTL_TEMP_W 8
// watchdog defaults: transmit recessive, receive output high
`define ICTL_TX_DEFAULT 1'b1
`define ICTL_RX_DEFAULT 1'b1

`endif

//--- include/ictl_pkg.sv
/*
  types shared by the isolated can transceiver logic model.
  assumes ictl_cfg.svh holds the numeric constants.
*/
package ictl_pkg;
  typedef enum logic [1:0] {
    ICTL_PULSE_NONE,
    ICTL_PULSE_SET,
    ICTL_PULSE_RESET
  } ictl_pulse_t;
endpackage

//--- logic/ictl_transceiver.sv
/*
  isolated can transceiver logic: two isolator channels (transmit data
  to the bus side, receive result back), bus driver with thermal
  shutdown hysteresis, receiver level classification, supply gating.
  assumes all inputs synchronous to clock_in; bus differential given
  in signed millivolts; die temperature in degrees C.
*/
// Operation
// - with both supplies on, standby off and transmit low the bus is driven dominant.
// - with both supplies on and transmit high or open the bus is recessive.
// - with the logic supply off the bus is held recessive.
// - open bus inputs read as recessive, receive high.
// - with the bus supply off the receive output is held high.
// - drivers turn off at 150 C and back on only at 140 C or below.
// - each input edge sends a set or reset pulse across the barrier.
// - the decoder is set by set pulses, cleared by reset pulses.
// - an idle input is refreshed with pulses showing its level.
// - a decoder with no pulses for the watchdog time goes to default.
// - transmit and receive each cross the barrier on their own channel.
`include "ictl_cfg.svh"

module ictl_channel #(
  parameter int CNT_W = `ICTL_CNT_W,
  parameter logic DEFAULT_LEVEL = 1'b1
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic enable_in,
  input wire logic src_powered_in,
  input wire logic data_in,
  output logic data_out
);
  import ictl_pkg::*;
  localparam logic [CNT_W-1:0] REFRESH_CYC = CNT_W'(`ICTL_REFRESH_CYC);
  localparam logic [CNT_W-1:0] WATCHDOG_CYC = CNT_W'(`ICTL_WATCHDOG_CYC);
  logic prev_reg;
  logic [CNT_W-1:0] idle_reg;
  logic [CNT_W-1:0] wd_reg;
  ictl_pulse_t pulse_reg;
  ictl_pulse_t pulse_next;
  logic edge_seen;

  assign edge_seen = data_in != prev_reg;

  // a single cycle pulse stands in for the ~1 ns barrier pulse
  always_comb begin
    pulse_next = ICTL_PULSE_NONE;
    if (src_powered_in && (edge_seen || idle_reg >= REFRESH_CYC - 1'b1)) begin
      pulse_next = data_in ? ICTL_PULSE_SET : ICTL_PULSE_RESET;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_reg <= DEFAULT_LEVEL;
      pulse_reg <= ICTL_PULSE_NONE;
    end else if (enable_in) begin
      prev_reg <= data_in;
      pulse_reg <= pulse_next;
    end
  end

  // encoder idle timer; restarts on every edge, refresh or supply loss,
  // so an unpowered sender cannot run the count past the refresh limit
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idle_reg <= '0;
    end else if (enable_in) begin
      if (!src_powered_in || pulse_next != ICTL_PULSE_NONE) begin
        idle_reg <= '0;
      end else begin
        idle_reg <= idle_reg + 1'b1;
      end
    end
  end

  // decoder watchdog; saturates so a dead sender never wraps back
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wd_reg <= '0;
    end else if (enable_in) begin
      if (pulse_reg != ICTL_PULSE_NONE) begin
        wd_reg <= '0;
      end else if (wd_reg < WATCHDOG_CYC) begin
        wd_reg <= wd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_out <= DEFAULT_LEVEL;
    end else if (enable_in) begin
      if (pulse_reg == ICTL_PULSE_SET) begin
        data_out <= 1'b1;
      end else if (pulse_reg == ICTL_PULSE_RESET) begin
        data_out <= 1'b0;
      end else if (wd_reg >= WATCHDOG_CYC) begin
        data_out <= DEFAULT_LEVEL;
      end
    end
  end

  decoder_follows_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    enable_in && pulse_reg == ICTL_PULSE_RESET |=> !data_out)
    else $error("decoder did not clear on reset pulse");

  refresh_idle_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    idle_reg <= REFRESH_CYC)
    else $error("idle input not refreshed in time");

  watchdog_default_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    enable_in && wd_reg >= WATCHDOG_CYC && pulse_reg == ICTL_PULSE_NONE
    |=> data_out == DEFAULT_LEVEL)
    else $error("watchdog did not force default");

  cover_watchdog_c: cover property (@(posedge clock_in)
    disable iff (!arst_n_in) wd_reg == WATCHDOG_CYC);
endmodule

module ictl_transceiver #(
  parameter int VID_W = `ICTL_VID_W,
  parameter int TEMP_W = `ICTL_TEMP_W
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic logic_supply_on_in,
  input wire logic bus_supply_on_in,
  input wire logic tx_data_in,
  input wire logic tx_floating_in,
  input wire logic slope_select_pin_in,
  input wire logic signed [VID_W-1:0] bus_differential_voltage_in,
  input wire logic bus_inputs_open_in,
  input wire logic [TEMP_W-1:0] die_temp_in,
  output logic canh_out,
  output logic canh_oe_n_out,
  output logic canl_out,
  output logic canl_oe_n_out,
  output logic rx_data_out,
  output logic rx_valid_out,
  output logic thermal_off_out,
  output logic standby_out
);
  import ictl_pkg::*;
  localparam logic signed [VID_W-1:0] DOM_MV = VID_W'(`ICTL_DOM_MV);
  localparam logic signed [VID_W-1:0] REC_MV = VID_W'(`ICTL_REC_MV);
  localparam logic [TEMP_W-1:0] TSD_ON = TEMP_W'(`ICTL_TSD_ON_C);
  localparam logic [TEMP_W-1:0] TSD_OFF = TEMP_W'(`ICTL_TSD_OFF_C);

  logic tx_level;
  logic tx_bus_side;
  logic rx_bus_level_reg;
  logic rx_logic_side;
  logic drive_dom;

  // floating transmit input is pulled to the recessive level
  assign tx_level = tx_data_in | tx_floating_in;

  ictl_channel #(.DEFAULT_LEVEL(`ICTL_TX_DEFAULT)) tx_chan_u (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .enable_in(clk_en_in),
    .src_powered_in(logic_supply_on_in),
    .data_in(tx_level),
    .data_out(tx_bus_side)
  );

  // receiver classifier; in the undefined band the last level holds
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_bus_level_reg <= `ICTL_RX_DEFAULT;
    end else if (clk_en_in) begin
      if (!bus_supply_on_in || bus_inputs_open_in) begin
        rx_bus_level_reg <= 1'b1;
      end else if (bus_differential_voltage_in >= DOM_MV) begin
        rx_bus_level_reg <= 1'b0;
      end else if (bus_differential_voltage_in <= REC_MV) begin
        rx_bus_level_reg <= 1'b1;
      end
    end
  end

  ictl_channel #(.DEFAULT_LEVEL(`ICTL_RX_DEFAULT)) rx_chan_u (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .enable_in(clk_en_in),
    .src_powered_in(bus_supply_on_in),
    .data_in(rx_bus_level_reg),
    .data_out(rx_logic_side)
  );

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_data_out <= `ICTL_RX_DEFAULT;
      rx_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      // a dead bus side would leave the decoder holding low until the
      // watchdog runs out, so the supply flag forces the output high
      rx_data_out <= bus_supply_on_in ? rx_logic_side
        : `ICTL_RX_DEFAULT;
      rx_valid_out <= logic_supply_on_in;
    end
  end

  // hysteresis: between the two thresholds the flag keeps its state
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thermal_off_out <= 1'b0;
    end else if (clk_en_in) begin
      if (die_temp_in >= TSD_ON) begin
        thermal_off_out <= 1'b1;
      end else if (die_temp_in <= TSD_OFF) begin
        thermal_off_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      standby_out <= 1'b0;
    end else if (clk_en_in) begin
      standby_out <= slope_select_pin_in;
    end
  end

  // standby and thermal shutdown both release the bus
  assign drive_dom = logic_supply_on_in && bus_supply_on_in && !tx_bus_side
    && !thermal_off_out && !standby_out;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      canh_out <= 1'b1;
      canl_out <= 1'b0;
      canh_oe_n_out <= 1'b1;
      canl_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      canh_out <= 1'b1;
      canl_out <= 1'b0;
      canh_oe_n_out <= !drive_dom;
      canl_oe_n_out <= !drive_dom;
    end
  end

  supply_off_recessive_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && !logic_supply_on_in |=> canh_oe_n_out && canl_oe_n_out)
    else $error("bus driven with logic supply off");

  thermal_release_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && thermal_off_out |=> canh_oe_n_out && canl_oe_n_out)
    else $error("driver active during thermal shutdown");

  thermal_hold_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && thermal_off_out && die_temp_in > TSD_OFF |=> thermal_off_out)
    else $error("thermal shutdown released above lower threshold");

  rx_bus_off_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && !bus_supply_on_in |=> rx_bus_level_reg)
    else $error("receive level not high with bus supply off");

  rx_dominant_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && bus_supply_on_in && !bus_inputs_open_in
    && bus_differential_voltage_in >= DOM_MV |=> !rx_bus_level_reg)
    else $error("dominant differential not reported low");

  rx_open_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && bus_inputs_open_in |=> rx_bus_level_reg)
    else $error("open bus not read as recessive");

  tx_dominant_a: assert property (@(posedge clock_in)
    disable iff (!arst_n_in)
    clk_en_in && drive_dom |=> !canh_oe_n_out && !canl_oe_n_out)
    else $error("dominant drive not applied");

  cover_dominant_c: cover property (@(posedge clock_in)
    disable iff (!arst_n_in) !canh_oe_n_out);
  cover_thermal_c: cover property (@(posedge clock_in)
    disable iff (!arst_n_in) $fell(thermal_off_out));
  cover_rx_low_c: cover property (@(posedge clock_in)
    disable iff (!arst_n_in) $fell(rx_data_out));
endmodule

//--- tb/ictl_bus_node.sv
/*
  bus model: our node and one remote node sharing the can wires.
  assumes the design drives dominant only with both oe_n lines low.
*/
module ictl_bus_node (
  input wire logic canh_oe_n_in,
  input wire logic canl_oe_n_in,
  input wire logic signed [15:0] remote_mv_in,
  output logic signed [15:0] vid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a dominant driver wins over whatever the remote node shows
  always_comb begin
    if (!canh_oe_n_in && !canl_oe_n_in) begin
      vid_out = 16'sh07D0;
    end else begin
      vid_out = remote_mv_in;
    end
  end
endmodule

//--- tb/ictl_transceiver_tb.sv
/*
  self-checking bench for the isolated can transceiver logic.
  assumes the bus model is compiled first; latencies from hand-over.
*/
`define CHK(nm, e, g) begin total_checks++; \
  if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp=%0b got=%0b", nm, e, g); end end

module ictl_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, arst_n_in = 0, clk_en_in = 1;
  logic lsup = 1, bsup = 1, tx = 1, txf = 0, slope = 0, open_in = 0;
  logic [7:0] temp = 8'h19;
  logic signed [15:0] rmv = 16'sh0000;
  logic signed [15:0] vid;
  logic canh, canh_oe_n, canl, canl_oe_n, rx, rxv, toff, stby;
  int n_fail = 0;
  int total_checks = 0;
  logic signed [15:0] mv_tab [6] = '{16'sh0384, 16'sh01F4, 16'sh0383,
    16'shFED4, 16'sh07D0, 16'sh02BC};
  logic rx_tab [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  always #2 clock_in = ~clock_in;

  ictl_transceiver DUT (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in), .logic_supply_on_in(lsup),
    .bus_supply_on_in(bsup), .tx_data_in(tx), .tx_floating_in(txf),
    .slope_select_pin_in(slope), .bus_differential_voltage_in(vid),
    .bus_inputs_open_in(open_in), .die_temp_in(temp),
    .canh_out(canh), .canh_oe_n_out(canh_oe_n), .canl_out(canl),
    .canl_oe_n_out(canl_oe_n), .rx_data_out(rx), .rx_valid_out(rxv),
    .thermal_off_out(toff), .standby_out(stby));

  ictl_bus_node bus (.canh_oe_n_in(canh_oe_n), .canl_oe_n_in(canl_oe_n),
    .remote_mv_in(rmv), .vid_out(vid));

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic chk_bus(input logic dom);
    `CHK("canh_oe_n", ~dom, canh_oe_n)
    `CHK("canl_oe_n", ~dom, canl_oe_n)
    if (dom) begin
      `CHK("canh", 1'b1, canh)
      `CHK("canl", 1'b0, canl)
    end
  endtask

  task automatic t_tx;
    tx = 0;
    step(3);
    chk_bus(1);
    step(7);
    `CHK("rx loopback", 1'b0, rx)
    tx = 1;
    step(3);
    chk_bus(0);
    txf = 1;
    tx = 0;
    step(3);
    chk_bus(0);
    txf = 0;
    tx = 1;
    step(8);
    `CHK("rx_valid on", 1'b1, rxv)
    // a low clock enable must freeze the bus drive
    clk_en_in = 0;
    tx = 0;
    step(5);
    chk_bus(0);
    clk_en_in = 1;
    step(3);
    chk_bus(1);
    tx = 1;
    step(8);
    $display("test tx done");
  endtask

  task automatic t_rx;
    // in-band entries must hold the level left by the entry before
    for (int i = 0; i < 6; i++) begin
      rmv = mv_tab[i];
      step(4);
      `CHK("rx level", rx_tab[i], rx)
    end
    open_in = 1;
    step(4);
    `CHK("rx open", 1'b1, rx)
    open_in = 0;
    rmv = 16'sh0000;
    step(4);
    $display("test rx done");
  endtask

  task automatic t_supply;
    // decoders are left low first, so the watchdog default is visible
    tx = 0;
    step(3);
    chk_bus(1);
    lsup = 0;
    step(3);
    chk_bus(0);
    `CHK("rx_valid", 1'b0, rxv)
    `CHK("tx hold", 1'b0, DUT.tx_bus_side)
    step(1300);
    `CHK("tx default", 1'b1, DUT.tx_bus_side)
    chk_bus(0);
    lsup = 1;
    step(300);
    chk_bus(1);
    `CHK("rx loop low", 1'b0, rx)
    tx = 1;
    bsup = 0;
    rmv = 16'sh07D0;
    step(5);
    `CHK("rx bus off", 1'b1, rx)
    `CHK("rx hold", 1'b0, DUT.rx_logic_side)
    step(1300);
    `CHK("rx default", 1'b1, DUT.rx_logic_side)
    `CHK("rx bus off late", 1'b1, rx)
    bsup = 1;
    rmv = 16'sh0000;
    step(300);
    $display("test supply done");
  endtask

  task automatic t_idle;
    // long enough to pass the watchdog if refresh never came
    tx = 0;
    step(1500);
    chk_bus(1);
    tx = 1;
    step(4);
    $display("test idle done");
  endtask

  task automatic t_thermal;
    temp = 8'h95;
    step(4);
    `CHK("thermal 149", 1'b0, toff)
    temp = 8'h96;
    step(1);
    `CHK("thermal 150", 1'b1, toff)
    tx = 0;
    step(4);
    chk_bus(0);
    temp = 8'h8D;
    step(4);
    `CHK("thermal 141", 1'b1, toff)
    temp = 8'h8C;
    step(1);
    `CHK("thermal 140", 1'b0, toff)
    step(3);
    chk_bus(1);
    tx = 1;
    temp = 8'h19;
    step(4);
    $display("test thermal done");
  endtask

  task automatic t_standby;
    slope = 1;
    step(1);
    `CHK("standby", 1'b1, stby)
    tx = 0;
    step(4);
    chk_bus(0);
    slope = 0;
    step(3);
    chk_bus(1);
    tx = 1;
    step(4);
    $display("test standby done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    step(20);
    chk_bus(0);
    `CHK("rx reset", 1'b1, rx)
    `CHK("rx_valid reset", 1'b0, rxv)
    arst_n_in = 1;
    step(2);
    t_tx();
    t_rx();
    t_supply();
    t_idle();
    t_thermal();
    t_standby();
    final_report();
  end

  // whole run is about 5000 cycles; this allows five times that
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule
